// ===== core/pwb_pkg.sv
// Function
// - period is the high byte as bits 15:8 joined with the low byte
// - duty of channels 0 to 3 is its high byte joined with its low byte
// - per channel 0 to 5 polarity bit: 0 passes the signal, 1 inverts it
// - brake flag sets when brake detection is enabled and the selected edge arrives
// - brake levels stay on the outputs after flag clear until run is set again
// - brake edge select bit 6: 0 means falling edge, 1 means rising edge
// - while braking each channel 0 to 5 is forced to its brake level bit
// - period, duty, polarity and brake data registers reset to zero
// - generator idles while run is 0 and runs while run is 1
// - load request moves period and duty to working copies at period end, then self-clears
// - counter clear bit zeroes the counter, reads 1 until done, then self-clears
package pwb_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 6;
  localparam int NUM_DUTY = 4;

  localparam logic [IDX_W-1:0] IDX_PERIOD_HI = 10'h0d1;
  localparam logic [IDX_W-1:0] IDX_POLARITY = 10'h0d6;
  localparam logic [IDX_W-1:0] IDX_BRAKE = 10'h0d7;
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h0d8;
  localparam logic [IDX_W-1:0] IDX_PERIOD_LO = 10'h0d9;
  localparam logic [IDX_W-1:0] IDX_BRAKE_EN = 10'h0e0;
  localparam logic [IDX_W-1:0] IDX_COUNT = 10'h0e1;
  localparam logic [IDX_W-1:0] IDX_DUTY_HI [NUM_DUTY] = '{10'h0d2, 10'h0d3, 10'h0d4, 10'h0d5};
  localparam logic [IDX_W-1:0] IDX_DUTY_LO [NUM_DUTY] = '{10'h0da, 10'h0db, 10'h0dc, 10'h0dd};

  localparam int CTRL_RUN_BIT = 7;
  localparam int CTRL_LOAD_BIT = 6;
  localparam int CTRL_CLR_BIT = 4;
  localparam int BRAKE_FLAG_BIT = 7;
  localparam int BRAKE_EDGE_BIT = 6;
  localparam int BRAKE_EN_BIT = 0;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [CNT_W-1:0] RST_WORD16 = 16'h0000;
  localparam logic [NUM_CH-1:0] RST_CH = 6'h00;
  // brake pin assumed to idle high, so reset gives no false edge
  localparam logic BRAKE_IDLE = 1'b1;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    logic hit;
    hit = (idx == IDX_PERIOD_HI) || (idx == IDX_PERIOD_LO) || (idx == IDX_POLARITY) ||
          (idx == IDX_BRAKE) || (idx == IDX_CTRL) || (idx == IDX_BRAKE_EN) ||
          (idx == IDX_COUNT);
    for (int i = 0; i < NUM_DUTY; i++)
    begin
      hit = hit || (idx == IDX_DUTY_HI[i]) || (idx == IDX_DUTY_LO[i]);
    end
    return hit;
  endfunction
endpackage

// ===== core/pwb_sync.sv
`timescale 1ns/1ps
module pwb_sync
  import pwb_pkg::*;
(
  input  logic clk_i,
  input  logic reset_n_i,
  input  logic pin_i,
  output logic rise_o,
  output logic fall_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s1_r <= BRAKE_IDLE;
      s2_r <= BRAKE_IDLE;
      s3_r <= BRAKE_IDLE;
      lvl_r <= BRAKE_IDLE;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      // a change counts only once two later stages agree
      if (s2_r == s3_r && s3_r != lvl_r)
      begin
        lvl_r <= s3_r;
        rise_o <= s3_r;
        fall_o <= ~s3_r;
      end
    end
  end
endmodule

// ===== core/pwb_counter.sv
`timescale 1ns/1ps
module pwb_counter
  import pwb_pkg::*;
(
  input  logic clk_i,
  input  logic reset_n_i,
  input  logic run_i,
  input  logic clear_i,
  input  logic [CNT_W-1:0] period_i,
  output logic [CNT_W-1:0] count_o,
  output logic period_end_o
);
  assign period_end_o = run_i && (count_o >= period_i);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count_o <= RST_WORD16;
    end
    else if (clear_i)
    begin
      count_o <= RST_WORD16;
    end
    else if (run_i)
    begin
      // >= so a shortened period never runs the counter through 16 bits
      if (period_end_o)
      begin
        count_o <= RST_WORD16;
      end
      else
      begin
        count_o <= count_o + 16'h0001;
      end
    end
  end
endmodule

// ===== core/pwb_top.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pwb_top
  import pwb_pkg::*;
(
  input  logic clk_i,
  input  logic reset_n_i,
  input  logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input  logic [DATA_W-1:0] s_axi_wdata_i,
  input  logic [3:0] s_axi_wstrb_i,
  input  logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input  logic s_axi_bready_i,
  input  logic [ADDR_W-1:0] s_axi_araddr_i,
  input  logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input  logic s_axi_rready_i,
  input  logic brake_pin_i,
  output logic [NUM_CH-1:0] pwm_o
);
  logic aw_rdy_r, w_rdy_r, w_strb0_r, wr_fire, wr_en, wr_ctrl, wr_brake;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_byte_r, period_hi_r, period_lo_r;
  logic [IDX_W-1:0] wr_idx, rd_idx;
  logic [DATA_W-1:0] rd_val;
  logic [7:0] duty_hi_r [NUM_DUTY];
  logic [7:0] duty_lo_r [NUM_DUTY];
  logic [CNT_W-1:0] period_shadow, period_work_r, cnt;
  logic [CNT_W-1:0] duty_shadow [NUM_DUTY];
  logic [CNT_W-1:0] duty_work_r [NUM_DUTY];
  logic [NUM_CH-1:0] pol_r, level_r, gen;
  logic edge_sel_r, brake_en_r, flag_r, brake_act_r, run_r, load_r, clr_r;
  logic period_end, load_now, brake_rise, brake_fall, brake_hit;

  assign s_axi_awready_o = aw_rdy_r;
  assign s_axi_wready_o = w_rdy_r;

  // a write completes only once both address and data are held
  assign wr_fire = !aw_rdy_r && !w_rdy_r && !s_axi_bvalid_o;
  assign wr_idx = reg_index(aw_addr_r);
  assign wr_en = wr_fire && w_strb0_r && is_mapped(wr_idx);
  assign wr_ctrl = wr_en && (wr_idx == IDX_CTRL);
  assign wr_brake = wr_en && (wr_idx == IDX_BRAKE);
  assign rd_idx = reg_index(s_axi_araddr_i);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      aw_rdy_r <= 1'b1;
      w_rdy_r <= 1'b1;
      aw_addr_r <= '0;
      w_byte_r <= RST_BYTE;
      w_strb0_r <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end
    else
    begin
      if (aw_rdy_r && s_axi_awvalid_i)
      begin
        aw_rdy_r <= 1'b0;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (w_rdy_r && s_axi_wvalid_i)
      begin
        w_rdy_r <= 1'b0;
        w_byte_r <= s_axi_wdata_i[7:0];
        w_strb0_r <= s_axi_wstrb_i[0];
      end
      if (wr_fire)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
        aw_rdy_r <= 1'b1;
        w_rdy_r <= 1'b1;
      end
    end
  end

  always_comb
  begin
    rd_val = '0;
    case (rd_idx)
      IDX_PERIOD_HI: rd_val[7:0] = period_hi_r;
      IDX_PERIOD_LO: rd_val[7:0] = period_lo_r;
      IDX_POLARITY: rd_val[NUM_CH-1:0] = pol_r;
      IDX_BRAKE: rd_val[7:0] = {flag_r, edge_sel_r, level_r};
      IDX_CTRL: rd_val[7:0] = {run_r, load_r, 1'b0, clr_r, 4'h0};
      IDX_BRAKE_EN: rd_val[BRAKE_EN_BIT] = brake_en_r;
      IDX_COUNT: rd_val[CNT_W-1:0] = cnt;
      default: ;
    endcase
    for (int i = 0; i < NUM_DUTY; i++)
    begin
      if (rd_idx == IDX_DUTY_HI[i])
      begin
        rd_val[7:0] = duty_hi_r[i];
      end
      if (rd_idx == IDX_DUTY_LO[i])
      begin
        rd_val[7:0] = duty_lo_r[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_arready_o && s_axi_arvalid_i)
      begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_val;
        s_axi_rresp_o <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid_o && s_axi_rready_i)
      begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // software copies; period and duty reach the generator only after a load
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      period_hi_r <= RST_BYTE;
      period_lo_r <= RST_BYTE;
      pol_r <= RST_CH;
      level_r <= RST_CH;
      edge_sel_r <= 1'b0;
      brake_en_r <= 1'b0;
      for (int i = 0; i < NUM_DUTY; i++)
      begin
        duty_hi_r[i] <= RST_BYTE;
        duty_lo_r[i] <= RST_BYTE;
      end
    end
    else if (wr_en)
    begin
      if (wr_idx == IDX_PERIOD_HI)
        period_hi_r <= w_byte_r;
      if (wr_idx == IDX_PERIOD_LO)
        period_lo_r <= w_byte_r;
      if (wr_idx == IDX_POLARITY)
        pol_r <= w_byte_r[NUM_CH-1:0];
      if (wr_idx == IDX_BRAKE_EN)
        brake_en_r <= w_byte_r[BRAKE_EN_BIT];
      if (wr_brake)
      begin
        edge_sel_r <= w_byte_r[BRAKE_EDGE_BIT];
        level_r <= w_byte_r[NUM_CH-1:0];
      end
      for (int i = 0; i < NUM_DUTY; i++)
      begin
        if (wr_idx == IDX_DUTY_HI[i])
          duty_hi_r[i] <= w_byte_r;
        if (wr_idx == IDX_DUTY_LO[i])
          duty_lo_r[i] <= w_byte_r;
      end
    end
  end

  assign period_shadow = {period_hi_r, period_lo_r};
  assign load_now = load_r && period_end;

  always_comb
  begin
    for (int i = 0; i < NUM_DUTY; i++)
    begin
      duty_shadow[i] = {duty_hi_r[i], duty_lo_r[i]};
    end
  end

  // working copies change only at a period boundary, so no runt pulse
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      period_work_r <= RST_WORD16;
      for (int i = 0; i < NUM_DUTY; i++)
      begin
        duty_work_r[i] <= RST_WORD16;
      end
    end
    else if (load_now)
    begin
      period_work_r <= period_shadow;
      for (int i = 0; i < NUM_DUTY; i++)
      begin
        duty_work_r[i] <= duty_shadow[i];
      end
    end
  end

  // later assignment wins, so a fresh request beats the hardware clear
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      run_r <= 1'b0;
      load_r <= 1'b0;
      clr_r <= 1'b0;
    end
    else
    begin
      if (load_now)
        load_r <= 1'b0;
      if (clr_r)
        clr_r <= 1'b0;
      if (wr_ctrl)
      begin
        run_r <= w_byte_r[CTRL_RUN_BIT];
        if (w_byte_r[CTRL_LOAD_BIT])
          load_r <= 1'b1;
        if (w_byte_r[CTRL_CLR_BIT])
          clr_r <= 1'b1;
      end
    end
  end

  pwb_counter u_counter (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .run_i(run_r),
    .clear_i(clr_r),
    .period_i(period_work_r),
    .count_o(cnt),
    .period_end_o(period_end)
  );

  pwb_sync u_brake_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(brake_pin_i),
    .rise_o(brake_rise),
    .fall_o(brake_fall)
  );

  assign brake_hit = brake_en_r && (edge_sel_r ? brake_rise : brake_fall);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      flag_r <= 1'b0;
      brake_act_r <= 1'b0;
    end
    else
    begin
      if (wr_brake && !w_byte_r[BRAKE_FLAG_BIT])
        flag_r <= 1'b0;
      // release needs a run write with the flag already cleared
      if (wr_ctrl && w_byte_r[CTRL_RUN_BIT] && !flag_r)
        brake_act_r <= 1'b0;
      if (brake_hit)
      begin
        flag_r <= 1'b1;
        brake_act_r <= 1'b1;
      end
    end
  end

  always_comb
  begin
    gen = RST_CH;
    for (int i = 0; i < NUM_DUTY; i++)
    begin
      gen[i] = run_r && (cnt < duty_work_r[i]);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pwm_o <= RST_CH;
    else if (brake_act_r)
      pwm_o <= level_r;
    else
      pwm_o <= gen ^ pol_r;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_clr_req;
    wr_ctrl && w_byte_r[CTRL_CLR_BIT];
  endsequence
  sequence s_clr_done;
    clr_r ##1 (cnt == RST_WORD16);
  endsequence

  chk_load_period: assert property
    (load_now && !wr_ctrl |=> period_work_r == $past(period_shadow) && !load_r)
    else $error("period not loaded at period end");
  chk_load_duty: assert property
    (load_now |=> duty_work_r[0] == $past(duty_shadow[0])) else $error("duty not loaded");
  chk_load_waits: assert property
    (load_r && !period_end |=> load_r && $stable(period_work_r)) else $error("early load");
  chk_polarity_out: assert property
    (!brake_act_r |=> pwm_o == ($past(gen) ^ $past(pol_r))) else $error("polarity wrong");
  chk_brake_rise: assert property
    (brake_en_r && edge_sel_r && brake_rise |=> flag_r && brake_act_r) else $error("no brake");
  chk_edge_select: assert property
    (brake_en_r && !edge_sel_r && brake_rise && !flag_r |=> !flag_r) else $error("wrong edge");
  chk_flag_sticky: assert property (flag_r && !wr_brake |=> flag_r)
    else $error("brake flag cleared by hardware");
  // one cycle only: a run write in the next cycle may release the brake
  chk_brake_hold: assert property (brake_act_r && !wr_ctrl |=> brake_act_r)
    else $error("brake released without run write");
  chk_brake_level: assert property (brake_act_r |=> pwm_o == $past(level_r))
    else $error("brake level not driven");
  chk_idle_hold: assert property (!run_r && !clr_r |=> $stable(cnt))
    else $error("counter moved while idle");
  chk_clear_counter: assert property (s_clr_req |=> s_clr_done)
    else $error("counter clear failed");
endmodule

// ===== sim/pwb_stage_model.sv
`timescale 1ns/1ps
module pwb_stage_model
  import pwb_pkg::*;
(
  input wire logic clk_i,
  input wire logic [NUM_CH-1:0] pwm_i,
  output logic brake_pin_o
);
  // the fault line idles high, the way a pulled-up stage output rests
  initial brake_pin_o = BRAKE_IDLE;

  // a slow stage reports its fault a few cycles late
  task automatic trip(input logic lvl, input int lag);
    repeat (lag) @(posedge clk_i);
    brake_pin_o <= lvl;
  endtask

  // gate-on time of each leg over n cycles
  task automatic measure(input int n, output int hi [NUM_CH]);
    hi = '{default: 0};
    repeat (n)
    begin
      @(negedge clk_i);
      for (int c = 0; c < NUM_CH; c++)
        hi[c] += int'(pwm_i[c]);
    end
  endtask
endmodule

// ===== sim/pwm_with_fault_brake_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pwm_with_fault_brake_tb_top;
  import pwb_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready;
  logic wready;
  logic bvalid;
  logic arready;
  logic rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic pin;
  logic [NUM_CH-1:0] pwm;
  logic [33:0] exp_q [$];
  logic [33:0] e;
  logic [15:0] duty [NUM_DUTY];
  logic [5:0] pol;
  logic [5:0] lv;
  // {enable, edge select, new pin level, flag expected}
  logic [3:0] st [5] = '{4'b1100, 4'b1111, 4'b0000, 4'b1010, 4'b1001};
  int hi [NUM_CH];
  int n_fail = 0;
  int comparisons = 0;
  int seed = 57715;

  always #5 clk_i = ~clk_i;

  pwb_top i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .brake_pin_i(pin), .pwm_o(pwm)
  );

  pwb_stage_model i_stage (
    .clk_i(clk_i),
    .pwm_i(pwm),
    .brake_pin_o(pin)
  );

  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // flags are sampled at the falling edge so the rising edge sees no race
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic a;
    logic w;
    logic b;
    logic [1:0] r;
    int n;
    @(posedge clk_i);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(negedge clk_i);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge clk_i);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b)
      begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 100)
    begin
      n_fail++;
      complete_run();
    end
    `CHK(r, er)
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    logic a;
    logic b;
    int n;
    exp_q.push_back({er, 24'h0, d});
    @(posedge clk_i);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(negedge clk_i);
      a = arvalid && arready;
      b = rvalid;
      @(posedge clk_i);
      if (a) arvalid <= 1'b0;
      if (b)
      begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 100)
    begin
      n_fail++;
      complete_run();
    end
  endtask

  always @(negedge clk_i)
    if (rvalid && rready)
    begin
      e = exp_q.pop_front();
      `CHK({rresp, rdata}, e)
    end

  // period 0x0104 gives 261 counts per cycle of the generator
  task automatic chk_duty(input logic [5:0] p);
    int x;
    i_stage.measure(261, hi);
    for (int c = 0; c < NUM_CH; c++)
    begin
      x = (c < NUM_DUTY) ? ((duty[c] < 261) ? int'(duty[c]) : 261) : 0;
      if (p[c]) x = 261 - x;
      `CHK(hi[c], x)
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clk_i);
    `CHK(pwm, RST_CH)
    reset_n_i <= 1'b1;
    rd(IDX_PERIOD_HI, RST_BYTE);
    rd(IDX_POLARITY, RST_BYTE);
    rd(IDX_BRAKE, RST_BYTE);
    for (int i = 0; i < NUM_DUTY; i++)
      rd(IDX_DUTY_HI[i], RST_BYTE);
    rd(10'h0f0, 8'h00, RESP_SLVERR);
    wr(10'h0f0, 8'hff, RESP_SLVERR);
    wr(IDX_PERIOD_HI, 8'h01);
    wr(IDX_PERIOD_LO, 8'h04);
    rd(IDX_PERIOD_HI, 8'h01);
    for (int i = 0; i < NUM_DUTY; i++)
    begin
      duty[i] = 16'($random(seed)) & 16'h01ff;
      wr(IDX_DUTY_HI[i], duty[i][15:8]);
      wr(IDX_DUTY_LO[i], duty[i][7:0]);
      rd(IDX_DUTY_HI[i], duty[i][15:8]);
      rd(IDX_DUTY_LO[i], duty[i][7:0]);
    end
    wr(IDX_CTRL, 8'hc0);
    repeat (5) @(posedge clk_i);
    rd(IDX_CTRL, 8'h80);
    chk_duty(6'h00);
    pol = 6'($random(seed));
    wr(IDX_POLARITY, {2'b00, pol});
    rd(IDX_POLARITY, {2'b00, pol});
    chk_duty(pol);
    wr(IDX_CTRL, 8'h10);
    rd(IDX_COUNT, 8'h00);
    rd(IDX_CTRL, 8'h00);
    repeat (20) @(posedge clk_i);
    `CHK(pwm, pol)
    rd(IDX_COUNT, 8'h00);
    for (int s = 0; s < 5; s++)
    begin
      lv = 6'($random(seed));
      wr(IDX_BRAKE_EN, {7'h00, st[s][3]});
      wr(IDX_BRAKE, {1'b0, st[s][2], lv});
      wr(IDX_CTRL, 8'h80);
      i_stage.trip(st[s][1], 3);
      repeat (12) @(posedge clk_i);
      rd(IDX_BRAKE, {st[s][0], st[s][2], lv});
      if (st[s][0])
      begin
        `CHK(pwm, lv)
        repeat (30) @(posedge clk_i);
        rd(IDX_BRAKE, {1'b1, st[s][2], lv});
        wr(IDX_BRAKE, {1'b0, st[s][2], lv});
        repeat (5) @(posedge clk_i);
        `CHK(pwm, lv)
      end
    end
    wr(IDX_CTRL, 8'h80);
    repeat (5) @(posedge clk_i);
    chk_duty(pol);
    complete_run();
  end
endmodule
